// ### rtl/mpv_pin_values.v
// Multifunction pin drive-value, input-state and pin configuration registers
`timescale 1ns/100ps
//
// Notes on behaviour
// - Fourteen write-only drive-value registers 0xf520-0xf52d, one per pin.
// - Mode 001 takes the pin's core level from its drive-value bit 0.
// - Drive bit 0 is the core-seen level, 0 low, 1 high; 15:1 reserved.
// - Fourteen read-only pin-state registers 0xf530-0xf53d log input pins.
// - State bit 0 reads pin level; bits 15:1 read zero.
// - Enable bit 0 gives the primary function; pin registers are ignored.
// - Modes: input, driven input, outputs, mic, error flag, select.
`include "mpv_consts.vh"

module mpv_pin_values (
   input  wire                          core_clk_i,
   input  wire                          rst_n_i,
   // Register port
   input  wire [`MPV_ADDR_W-1:0]        reg_addr_i,
   input  wire [`MPV_DATA_W-1:0]        reg_wdata_i,
   input  wire                          reg_wr_i,
   input  wire                          reg_rd_i,
   output reg  [`MPV_DATA_W-1:0]        reg_rdata_o,
   // Pins
   input  wire [`MPV_NUM_PINS-1:0]      multifunction_pin_in_i,
   output reg  [`MPV_NUM_PINS-1:0]      multifunction_pin_out_o,
   output reg  [`MPV_NUM_PINS-1:0]      multifunction_pin_oe_o,
   output reg  [`MPV_NUM_PINS-1:0]      multifunction_pin_pullup_o,
   // Primary clock or control function of each pin
   input  wire [`MPV_NUM_PINS-1:0]      primary_out_i,
   input  wire [`MPV_NUM_PINS-1:0]      primary_oe_i,
   output reg  [`MPV_NUM_PINS-1:0]      primary_in_o,
   // Sources for the output modes
   input  wire [`MPV_NUM_PINS-1:0]      core_out_level_i,
   input  wire                          error_flag_i,
   input  wire                          spi_select_n_i,
   // Levels handed to the processing core
   output reg  [`MPV_NUM_PINS-1:0]      core_in_level_o,
   output reg  [`MPV_NUM_PINS-1:0]      mic_data_o,
   output reg  [`MPV_NUM_PINS-1:0]      mic_data_valid_o
);

   // Stored state, one bit or one field per pin
   reg  [`MPV_NUM_PINS-1:0]              drive_level_bit;
   reg  [`MPV_NUM_PINS-1:0]              input_level_bit;
   reg  [`MPV_NUM_PINS-1:0]              multifunction_select;
   reg  [`MPV_NUM_PINS*`MPV_MODE_W-1:0]  pin_function_select;

   // Two-flop synchroniser for the pins
   reg  [`MPV_NUM_PINS-1:0]              pin_meta;
   reg  [`MPV_NUM_PINS-1:0]              pin_sync;

   // Address decode
   wire [`MPV_IDX_W-1:0]                 addr_idx;
   wire [`MPV_BANK_MSB-`MPV_BANK_LSB:0]  addr_bank;
   wire                                  idx_ok;
   wire                                  hit_drive;
   wire                                  hit_state;
   wire                                  hit_cfg;
   wire                                  wr_drive;
   wire                                  wr_cfg;

   // Read data for the cycle after the strobe
   reg  [`MPV_DATA_W-1:0]                next_rdata;

   assign addr_idx  = reg_addr_i[`MPV_IDX_W-1:0];
   assign addr_bank = reg_addr_i[`MPV_BANK_MSB:`MPV_BANK_LSB];
   assign idx_ok    = (addr_idx <= `MPV_LAST_IDX);
   assign hit_drive = idx_ok && (addr_bank == `MPV_DRIVE_BANK);
   assign hit_state = idx_ok && (addr_bank == `MPV_STATE_BANK);
   assign hit_cfg   = idx_ok && (addr_bank == `MPV_CFG_BANK);

   // State bank has no write path, so writes to it fall away
   assign wr_drive  = reg_wr_i && hit_drive;
   assign wr_cfg    = reg_wr_i && hit_cfg;

   // Everything that repeats per pin
   genvar g;
   generate
      for (g = 0; g < `MPV_NUM_PINS; g = g + 1) begin : gen_pin
         localparam [`MPV_IDX_W-1:0] pin_idx = g;

         wire                   sel_this;
         wire [`MPV_MODE_W-1:0] mode;
         reg                    next_out;
         reg                    next_oe;
         reg                    next_pullup;
         reg                    next_primary;
         reg                    next_core;
         reg                    next_mic;
         reg                    next_mic_valid;
         reg                    next_level;

         assign sel_this = (addr_idx == pin_idx);
         assign mode     = pin_function_select[g*`MPV_MODE_W +: `MPV_MODE_W];

         // Pin synchroniser; only pin_sync is read by logic
         always @(posedge core_clk_i) begin
            if (!rst_n_i) begin
               pin_meta[g] <= `MPV_PIN_RST;
               pin_sync[g] <= `MPV_PIN_RST;
            end else begin
               pin_meta[g] <= multifunction_pin_in_i[g];
               pin_sync[g] <= pin_meta[g];
            end
         end

         // Drive value; reserved bits 15:1 are not stored
         always @(posedge core_clk_i) begin
            if (!rst_n_i) begin
               drive_level_bit[g] <= `MPV_LEVEL_RST;
            end else if (wr_drive && sel_this) begin
               drive_level_bit[g] <=
                  reg_wdata_i[`MPV_LEVEL_BIT];
            end
         end

         // Enable and function select
         always @(posedge core_clk_i) begin
            if (!rst_n_i) begin
               multifunction_select[g] <= `MPV_EN_RST;
               pin_function_select[g*`MPV_MODE_W +: `MPV_MODE_W] <=
                  `MPV_MODE_RST;
            end else if (wr_cfg && sel_this) begin
               multifunction_select[g] <= reg_wdata_i[`MPV_EN_BIT];
               pin_function_select[g*`MPV_MODE_W +: `MPV_MODE_W] <=
                  reg_wdata_i[`MPV_MODE_MSB:`MPV_MODE_LSB];
            end
         end

         // Pin function steering; every branch sets every value
         always @* begin
            if (!multifunction_select[g]) begin
               // Primary function owns the pin; pin registers ignored
               next_out       = primary_out_i[g];
               next_oe        = primary_oe_i[g];
               next_pullup    = 1'b0;
               next_primary   = pin_sync[g];
               next_core      = 1'b0;
               next_mic       = 1'b0;
               next_mic_valid = 1'b0;
               next_level     = input_level_bit[g];
            end else begin
               case (mode)
                  // Plain input: core and state follow the pin
                  `MPV_MODE_INPUT: begin
                     next_out       = 1'b0;
                     next_oe        = 1'b0;
                     next_pullup    = 1'b0;
                     next_primary   = 1'b0;
                     next_core      = pin_sync[g];
                     next_mic       = 1'b0;
                     next_mic_valid = 1'b0;
                     next_level     = pin_sync[g];
                  end

                  // Register value replaces the pin level for the core
                  `MPV_MODE_CTRL_IN: begin
                     next_out       = 1'b0;
                     next_oe        = 1'b0;
                     next_pullup    = 1'b0;
                     next_primary   = 1'b0;
                     next_core      = drive_level_bit[g];
                     next_mic       = 1'b0;
                     next_mic_valid = 1'b0;
                     next_level     = pin_sync[g];
                  end

                  // Output with pull-up
                  `MPV_MODE_OUT_PU: begin
                     next_out       = core_out_level_i[g];
                     next_oe        = 1'b1;
                     next_pullup    = 1'b1;
                     next_primary   = 1'b0;
                     next_core      = 1'b0;
                     next_mic       = 1'b0;
                     next_mic_valid = 1'b0;
                     next_level     = input_level_bit[g];
                  end

                  // Output without pull-up
                  `MPV_MODE_OUT_NOPU: begin
                     next_out       = core_out_level_i[g];
                     next_oe        = 1'b1;
                     next_pullup    = 1'b0;
                     next_primary   = 1'b0;
                     next_core      = 1'b0;
                     next_mic       = 1'b0;
                     next_mic_valid = 1'b0;
                     next_level     = input_level_bit[g];
                  end

                  // Microphone data input
                  `MPV_MODE_MIC: begin
                     next_out       = 1'b0;
                     next_oe        = 1'b0;
                     next_pullup    = 1'b0;
                     next_primary   = 1'b0;
                     next_core      = 1'b0;
                     next_mic       = pin_sync[g];
                     next_mic_valid = 1'b1;
                     next_level     = pin_sync[g];
                  end

                  // Error flag output
                  `MPV_MODE_ERR: begin
                     next_out       = error_flag_i;
                     next_oe        = 1'b1;
                     next_pullup    = 1'b0;
                     next_primary   = 1'b0;
                     next_core      = 1'b0;
                     next_mic       = 1'b0;
                     next_mic_valid = 1'b0;
                     next_level     = input_level_bit[g];
                  end

                  // Select line of the serial master
                  `MPV_MODE_SS: begin
                     next_out       = spi_select_n_i;
                     next_oe        = 1'b1;
                     next_pullup    = 1'b0;
                     next_primary   = 1'b0;
                     next_core      = 1'b0;
                     next_mic       = 1'b0;
                     next_mic_valid = 1'b0;
                     next_level     = input_level_bit[g];
                  end

                  // Unused code: pin left undriven, treated as input
                  default: begin
                     next_out       = 1'b0;
                     next_oe        = 1'b0;
                     next_pullup    = 1'b0;
                     next_primary   = 1'b0;
                     next_core      = pin_sync[g];
                     next_mic       = 1'b0;
                     next_mic_valid = 1'b0;
                     next_level     = pin_sync[g];
                  end
               endcase
            end
         end

         // Output and state flops for this pin
         always @(posedge core_clk_i) begin
            if (!rst_n_i) begin
               input_level_bit[g]            <= `MPV_LEVEL_RST;
               multifunction_pin_out_o[g]    <= `MPV_PIN_RST;
               multifunction_pin_oe_o[g]     <= `MPV_PIN_RST;
               multifunction_pin_pullup_o[g] <= `MPV_PIN_RST;
               primary_in_o[g]               <= `MPV_PIN_RST;
               core_in_level_o[g]            <= `MPV_PIN_RST;
               mic_data_o[g]                 <= `MPV_PIN_RST;
               mic_data_valid_o[g]           <= `MPV_PIN_RST;
            end else begin
               input_level_bit[g]            <= next_level;
               multifunction_pin_out_o[g]    <= next_out;
               multifunction_pin_oe_o[g]     <= next_oe;
               multifunction_pin_pullup_o[g] <= next_pullup;
               primary_in_o[g]               <= next_primary;
               core_in_level_o[g]            <= next_core;
               mic_data_o[g]                 <= next_mic;
               mic_data_valid_o[g]           <= next_mic_valid;
            end
         end
      end
   endgenerate

   // Read path: data stand only in the cycle after the strobe
   always @* begin
      next_rdata = `MPV_RDATA_RST;
      if (reg_rd_i) begin
         if (hit_state) begin
            next_rdata[`MPV_LEVEL_BIT] =
               input_level_bit[addr_idx];
         end else if (hit_cfg) begin
            next_rdata[`MPV_EN_BIT] = multifunction_select[addr_idx];
            next_rdata[`MPV_MODE_MSB:`MPV_MODE_LSB] =
               pin_function_select[addr_idx*`MPV_MODE_W +: `MPV_MODE_W];
         end
         // Drive bank is write-only and reads zero, as do holes
      end
   end

   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= `MPV_RDATA_RST;
      end else begin
         reg_rdata_o <= next_rdata;
      end
   end

endmodule

// ### rtl/mpv_consts.vh
// Constants for the multifunction pin value register block
`ifndef MPV_CONSTS_VH
`define MPV_CONSTS_VH

// Number of multifunction pins and register geometry
`define MPV_NUM_PINS        14
`define MPV_ADDR_W          16
`define MPV_DATA_W          16
`define MPV_IDX_W           4
`define MPV_LAST_IDX        4'hd

// Bank bases; the low nibble of the address is the pin index
`define MPV_DRIVE_BASE      16'hf520
`define MPV_DRIVE_LAST      16'hf52d
`define MPV_STATE_BASE      16'hf530
`define MPV_STATE_LAST      16'hf53d
`define MPV_CFG_BASE        16'hf540
`define MPV_CFG_LAST        16'hf54d
`define MPV_BANK_MSB        15
`define MPV_BANK_LSB        4
`define MPV_DRIVE_BANK      12'hf52
`define MPV_STATE_BANK      12'hf53
`define MPV_CFG_BANK        12'hf54

// Field positions
`define MPV_LEVEL_BIT       0
`define MPV_EN_BIT          0
`define MPV_MODE_LSB        1
`define MPV_MODE_MSB        3
`define MPV_MODE_W          3

// Pin function select encodings
`define MPV_MODE_INPUT      3'h0
`define MPV_MODE_CTRL_IN    3'h1
`define MPV_MODE_OUT_PU     3'h2
`define MPV_MODE_OUT_NOPU   3'h3
`define MPV_MODE_MIC        3'h4
`define MPV_MODE_ERR        3'h5
`define MPV_MODE_SS         3'h6

// Reset values
`define MPV_DRIVE_RST       16'h0000
`define MPV_STATE_RST       16'h0000
`define MPV_CFG_RST         16'h0000
`define MPV_RDATA_RST       16'h0000
`define MPV_LEVEL_RST       1'b0
`define MPV_EN_RST          1'b0
`define MPV_MODE_RST        3'h0
`define MPV_PIN_RST         1'b0

`endif

// ### bench/mpv_pin_values_monitor.sv
// Checker watching the pin value register block ports
`timescale 1ns/100ps
module mpv_pin_values_monitor (
   input wire        core_clk_i,
   input wire        rst_n_i,
   input wire [15:0] reg_addr_i,
   input wire        reg_rd_i,
   input wire [15:0] reg_rdata_o,
   input wire [13:0] multifunction_pin_oe_o,
   input wire [13:0] multifunction_pin_pullup_o,
   input wire [13:0] core_in_level_o,
   input wire [13:0] mic_data_o,
   input wire [13:0] mic_data_valid_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 16'h0000; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not idle");
   property p_drive_wo;
      reg_rd_i && reg_addr_i[15:4] == 12'hf52 |=> reg_rdata_o == 16'h0000;
   endproperty
   a_drive_wo: assert property (p_drive_wo)
      else $error("drive bank readable");
   property p_state_rsvd;
      reg_rd_i && reg_addr_i[15:4] == 12'hf53 |=> reg_rdata_o[15:1] == 15'h0;
   endproperty
   a_state_rsvd: assert property (p_state_rsvd)
      else $error("state upper bits set");
   property p_gap; reg_rd_i && reg_addr_i[3:0] > 4'hd |=> !reg_rdata_o;
   endproperty
   a_gap: assert property (p_gap)
      else $error("gap address readable");
   property p_mic_core; (mic_data_valid_o & core_in_level_o) == 14'h0;
   endproperty
   a_mic_core: assert property (p_mic_core)
      else $error("mic pin seen by core");
   property p_core_oe; (core_in_level_o & multifunction_pin_oe_o) == 14'h0;
   endproperty
   a_core_oe: assert property (p_core_oe)
      else $error("input pin driven");
   property p_pullup;
      (multifunction_pin_pullup_o & ~multifunction_pin_oe_o) == 14'h0;
   endproperty
   a_pullup: assert property (p_pullup)
      else $error("pull-up without drive");
   property p_mic_data; (mic_data_o & ~mic_data_valid_o) == 14'h0;
   endproperty
   a_mic_data: assert property (p_mic_data)
      else $error("mic data without valid");
endmodule
bind mpv_pin_values mpv_pin_values_monitor u_mon (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .multifunction_pin_oe_o(multifunction_pin_oe_o),
   .multifunction_pin_pullup_o(multifunction_pin_pullup_o),
   .core_in_level_o(core_in_level_o), .mic_data_o(mic_data_o),
   .mic_data_valid_o(mic_data_valid_o));

// ### bench/mpv_pin_partner.sv
// Model of the outside levels on the multifunction pins
`timescale 1ns/100ps
module mpv_pin_partner (
   input  wire [13:0] level_i,
   input  wire [13:0] drv_i,
   input  wire [13:0] oe_i,
   output wire [13:0] pin_o
);
   // Device wins where it drives, else the outside source
   assign pin_o = (oe_i & drv_i) | (~oe_i & level_i);
endmodule

// ### bench/mpv_pin_values_tb_top.sv
// Self-checking bench for the pin value register block
`timescale 1ns/100ps
module mpv_pin_values_tb_top;
   reg         clk = 1'b0;
   reg         rst_n = 1'b0;
   reg  [15:0] addr = 16'h0000;
   reg  [15:0] wdata = 16'h0000;
   reg         wr = 1'b0;
   reg         rd = 1'b0;
   reg  [13:0] ext = 14'h0000;
   reg  [13:0] cout = 14'h0000;
   reg  [13:0] prim = 14'h0000;
   reg         errf = 1'b0;
   reg         ssn = 1'b0;
   reg  [13:0] poen = 14'h0000;
   reg  [15:0] d;
   wire [15:0] rdata;
   wire [13:0] pin, pout, poe, ppu, pprim, core, mic, micv;
   integer     miscompares = 0;
   integer     checks_done = 0;
   integer     n;
   initial forever #4 clk = ~clk;
   mpv_pin_partner u_far (.level_i(ext), .drv_i(pout), .oe_i(poe),
      .pin_o(pin));
   mpv_pin_values dut (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .multifunction_pin_in_i(pin), .multifunction_pin_out_o(pout),
      .multifunction_pin_oe_o(poe), .multifunction_pin_pullup_o(ppu),
      .primary_out_i(prim), .primary_oe_i(poen), .primary_in_o(pprim),
      .core_out_level_i(cout), .error_flag_i(errf), .spi_select_n_i(ssn),
      .core_in_level_o(core), .mic_data_o(mic), .mic_data_valid_o(micv));
   task chk(input string what, input [15:0] seen, input [15:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0s exp %h seen %h", what, exp, seen);
         end
      end
   endtask
   task wr_reg(input [15:0] a, input [15:0] v);
      begin
         @(posedge clk);
         addr <= a; wdata <= v; wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rd_reg(input [15:0] a);
      begin
         @(posedge clk);
         addr <= a; rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         @(negedge clk);
         d = rdata;
      end
   endtask
   task cfg(input [3:0] p, input [2:0] m, input e);
      wr_reg({12'hf54, p}, {12'h000, m, e});
   endtask
   task settle;
      begin repeat (4) @(posedge clk); #1; end
   endtask
   task close_out;
      begin
         $display("checks %0d miscompares %0d", checks_done, miscompares);
         if (miscompares == 0 && checks_done > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task t_reset;
      for (n = 0; n < 14; n = n + 1) begin
         rd_reg({12'hf53, n[3:0]}); chk("state", d, 16'h0000);
         rd_reg({12'hf52, n[3:0]}); chk("drive", d, 16'h0000);
      end
   endtask
   task t_drive;
      begin
         cfg(4'h3, 3'h1, 1'b1); cfg(4'hd, 3'h1, 1'b1);
         wr_reg(16'hf523, 16'hffff); wr_reg(16'hf52d, 16'h0001);
         wr_reg(16'hf524, 16'h0001); settle;
         chk("core3", core[3], 16'h0001);
         chk("core13", core[13], 16'h0001);
         chk("core4", core[4], 16'h0000);
         wr_reg(16'hf523, 16'hfffe); settle;
         chk("core3 low", core[3], 16'h0000);
         $display("t_drive done");
      end
   endtask
   task t_input;
      begin
         ext <= 14'h2001; cfg(4'h0, 3'h0, 1'b1); cfg(4'hd, 3'h0, 1'b1); settle;
         rd_reg(16'hf530); chk("st0", d, 16'h0001);
         rd_reg(16'hf53d); chk("st13", d, 16'h0001);
         rd_reg(16'hf531); chk("st1", d, 16'h0000);
         wr_reg(16'hf530, 16'h0000);
         rd_reg(16'hf530); chk("st0 ro", d, 16'h0001);
         rd_reg(16'hf53e); chk("gap", d, 16'h0000);
         chk("core0", core[0], 16'h0001);
         $display("t_input done");
      end
   endtask
   task t_disable;
      begin
         cfg(4'h5, 3'h1, 1'b0); wr_reg(16'hf525, 16'h0001);
         ext <= 14'h2021; settle;
         chk("core5", core[5], 16'h0000);
         chk("prim5", pprim[5], 16'h0001);
         prim <= 14'h0020; poen <= 14'h0020; settle;
         chk("pout5", pout[5], 16'h0001);
         chk("poe5", poe[5], 16'h0001);
         chk("core5 drv", core[5], 16'h0000);
         prim <= 14'h0000; poen <= 14'h0000; settle;
         chk("poe5 off", poe[5], 16'h0000);
         $display("t_disable done");
      end
   endtask
   task t_modes;
      begin
         cout <= 14'h3fff; errf <= 1'b1; ssn <= 1'b1; ext <= 14'h2061;
         for (n = 2; n < 8; n = n + 1) begin
            cfg(4'h6, n[2:0], 1'b1); settle;
            chk("oe6", poe[6], {15'h0, n != 4 && n != 7});
            chk("pu6", ppu[6], {15'h0, n == 2});
            chk("micv6", micv[6], {15'h0, n == 4});
            chk("mic6", mic[6], {15'h0, n == 4});
            chk("out6", pout[6], {15'h0, n != 4 && n != 7});
            chk("core6", core[6], {15'h0, n == 7});
         end
         $display("t_modes done");
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_reset; $display("t_reset done");
      t_drive; t_input; t_disable; t_modes;
      close_out;
   end
   initial begin
      #100000;
      miscompares = miscompares + 1;
      close_out;
   end
endmodule
